// ==== pcfg_port_top.sv ====
// Purpose: registers and pin control for two configurable ports
// Assumes: one hclk domain; AHB-Lite slave with no wait states
// Notes: pins leave as pull enables; the pad model resolves the level
`timescale 1ns/1ps
// Function
// [R1] Two mode bits select each pin's type
// [R2] Shared reset pin stays input only
// [R3] Quasi mode: very weak pull-up when latch 1
// [R4] Quasi mode: weak pull-up when latch, pin high
// [R5] Quasi latch rise: strong pull-up two cycles
// [R6] Quasi mode: pull-down when latch holds 0
// [R7] Open drain: no pull-ups, pull-down on 0
// [R8] Board supplies pull-up for open drain
// [R9] Push-pull: strong up on 1, down on 0
// [R10] Input only: all released, filtered input
// [R11] Disabled port 0 inputs read as zero
// [R12] Every reset clears input disable bits
// [R13] All pins input only after power-up
// [R14] Clock or reset use removes general pins
// [R15] Selected enabled converter input disconnects pin
// [R16] Mode registers reset to input only
module pcfg_port_top (
  input wire logic hclk, // Bus and core clock
  input wire logic hresetn, // Async reset, active low
  input wire pcfg_pkg::pcfg_ahb_req_t ahb_req, // AHB-Lite request
  output pcfg_pkg::pcfg_ahb_rsp_t ahb_rsp, // AHB-Lite response
  input wire logic [pcfg_pkg::PW-1:0] p0_pin_in, // Port 0 pad levels
  input wire logic [pcfg_pkg::PW-1:0] p1_pin_in, // Port 1 pad levels
  input wire logic ext_clk_sel, // Config: pin used as clock input
  input wire logic ext_reset_sel, // Config: pin used as reset input
  output pcfg_pkg::pcfg_drive_t p0_drive, // Port 0 driver enables
  output pcfg_pkg::pcfg_drive_t p1_drive // Port 1 driver enables
);
  import pcfg_pkg::*;

  typedef struct packed {
    logic [1:0][PW-1:0] latch;
    logic [1:0][PW-1:0] mode_high;
    logic [1:0][PW-1:0] mode_low;
    logic [PW-1:0] in_dis;
    logic [PW-1:0] conv_sel;
    logic conv_en;
    logic ext_clk;
    logic ext_rst;
    logic strap_done;
    logic dph_wr;
    logic [7:0] dph_addr;
    pcfg_ahb_rsp_t rsp;
  } pcfg_top_st_t;

  pcfg_top_st_t q, d;
  logic [1:0][PW-1:0] pin_in;
  logic [1:0][PW-1:0] level;
  logic [1:0][PW-1:0] taken;
  logic [1:0][PW-1:0] pin_fix;
  logic [1:0][PW-1:0] mh_eff;
  logic [1:0][PW-1:0] ml_eff;
  logic [1:0][PW-1:0] quasi;
  logic [1:0][PW-1:0] pushp;
  logic [1:0][PW-1:0] opend;
  logic [1:0][PW-1:0] inonly;
  logic [3:0] io_cnt;
  logic sel;
  pcfg_drive_t drv [2];

  // Pins lost to the clock input or the reset input
  function automatic logic [1:0][PW-1:0] pcfg_taken(input pcfg_top_st_t s);
    logic [1:0][PW-1:0] t;
    t[0] = s.ext_clk ? P0_CLKIN_PIN : '0; // [R14]
    t[1] = s.ext_rst ? P1_RESET_PIN : '0; // [R14]
    return t;
  endfunction

  // Value that software sees on a port read
  function automatic logic [PW-1:0] pcfg_port_val(input pcfg_top_st_t s,
      input logic port, input logic [PW-1:0] lvl);
    logic [1:0][PW-1:0] t;
    logic [PW-1:0] disc;
    t = pcfg_taken(s);
    disc = s.in_dis | (s.conv_en ? s.conv_sel : '0); // [R11] [R15]
    if (port) begin
      return lvl & P1_PRESENT & ~t[1];
    end
    return lvl & P0_PRESENT & ~t[0] & ~disc; // [R11] [R15]
  endfunction

  // Read mux; unmapped addresses read as zero
  function automatic logic [31:0] pcfg_read(input pcfg_top_st_t s, input logic [7:0] a,
      input logic [1:0][PW-1:0] lvl, input logic [3:0] cnt);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      OFS_P0_LATCH: r[PW-1:0] = s.latch[0];
      OFS_P1_LATCH: r[PW-1:0] = s.latch[1];
      OFS_P0_MODE_HIGH: r[PW-1:0] = s.mode_high[0];
      OFS_P0_MODE_LOW: r[PW-1:0] = s.mode_low[0];
      OFS_P1_MODE_HIGH: r[PW-1:0] = s.mode_high[1];
      OFS_P1_MODE_LOW: r[PW-1:0] = s.mode_low[1];
      OFS_P0_IN_DIS: r[PW-1:0] = s.in_dis;
      OFS_P0_PIN: r[PW-1:0] = pcfg_port_val(s, 1'b0, lvl[0]);
      OFS_P1_PIN: r[PW-1:0] = pcfg_port_val(s, 1'b1, lvl[1]);
      OFS_CONV: begin
        r[PW-1:0] = s.conv_sel;
        r[CONV_EN_BIT] = s.conv_en;
      end
      OFS_STATUS: begin
        r[3:0] = cnt;
        r[STAT_CLK_BIT] = s.ext_clk;
        r[STAT_RST_BIT] = s.ext_rst;
      end
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  assign pin_in = {p1_pin_in, p0_pin_in};

  // Force fixed, absent and taken pins into input-only mode
  always_comb begin
    taken = pcfg_taken(q);
    pin_fix[0] = taken[0] | ~P0_PRESENT; // [R14]
    pin_fix[1] = taken[1] | P1_INPUT_ONLY | ~P1_PRESENT; // [R2] [R14]
    mh_eff = q.mode_high | pin_fix;
    ml_eff = q.mode_low & ~pin_fix;
    io_cnt = 4'(pcfg_popcnt(P0_PRESENT & ~taken[0]) + pcfg_popcnt(P1_PRESENT & ~taken[1]));
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < PW; i++) begin
        quasi[p][i] = pcfg_mode(mh_eff[p][i], ml_eff[p][i]) == MODE_QUASI;
        pushp[p][i] = pcfg_mode(mh_eff[p][i], ml_eff[p][i]) == MODE_PUSH_PULL;
        opend[p][i] = pcfg_mode(mh_eff[p][i], ml_eff[p][i]) == MODE_OPEN_DRAIN;
        inonly[p][i] = pcfg_mode(mh_eff[p][i], ml_eff[p][i]) == MODE_INPUT;
      end
    end
  end

  // Input filter and driver logic for each port
  for (genvar p = 0; p < 2; p++) begin : g_port
    pcfg_pin_sync #(.W(PW)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(pin_in[p]),
      .level(level[p])
    );
    pcfg_pin_drive u_drive (
      .hclk(hclk),
      .hresetn(hresetn),
      .mode_high(mh_eff[p]),
      .mode_low(ml_eff[p]),
      .latch(q.latch[p]),
      .level(level[p]),
      .drive(drv[p])
    );
  end

  // Straps, bus write in data phase, read data loaded in address phase
  always_comb begin
    d = q;
    sel = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.ext_clk = ext_clk_sel;
      d.ext_rst = ext_reset_sel;
    end
    if (q.dph_wr) begin
      case (q.dph_addr)
        OFS_P0_LATCH: d.latch[0] = ahb_req.hwdata[PW-1:0];
        OFS_P1_LATCH: d.latch[1] = ahb_req.hwdata[PW-1:0];
        OFS_P0_MODE_HIGH: d.mode_high[0] = ahb_req.hwdata[PW-1:0]; // [R1]
        OFS_P0_MODE_LOW: d.mode_low[0] = ahb_req.hwdata[PW-1:0]; // [R1]
        OFS_P1_MODE_HIGH: d.mode_high[1] = ahb_req.hwdata[PW-1:0]; // [R1]
        OFS_P1_MODE_LOW: d.mode_low[1] = ahb_req.hwdata[PW-1:0]; // [R1]
        OFS_P0_IN_DIS: d.in_dis = ahb_req.hwdata[PW-1:0]; // [R11]
        OFS_CONV: begin
          d.conv_sel = ahb_req.hwdata[PW-1:0]; // [R15]
          d.conv_en = ahb_req.hwdata[CONV_EN_BIT];
        end
        default: d.conv_en = q.conv_en;
      endcase
    end
    d.dph_wr = sel && ahb_req.hwrite;
    d.dph_addr = ahb_req.haddr[7:0];
    d.rsp.hreadyout = 1'b1;
    d.rsp.hresp = HRESP_OKAY;
    if (sel && !ahb_req.hwrite) begin
      // Built from d so a read right behind a write sees the new value
      d.rsp.hrdata = pcfg_read(d, ahb_req.haddr[7:0], level, io_cnt);
    end
  end

  // Every reset source restores the input-only, inputs-enabled state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.latch <= {2{LATCH_RST}};
      q.mode_high <= {2{MODE_HIGH_RST}}; // [R13] [R16]
      q.mode_low <= {2{MODE_LOW_RST}}; // [R13] [R16]
      q.in_dis <= IN_DIS_RST; // [R12]
      q.conv_sel <= CONV_SEL_RST;
      q.rsp.hreadyout <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign ahb_rsp = q.rsp;
  assign p0_drive = drv[0];
  assign p1_drive = drv[1];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Bus always answers at once and OKAY
  a_bus_okay_ready: assert property (ahb_rsp.hreadyout && ahb_rsp.hresp == HRESP_OKAY)
    else $error("bus answer not ready or not okay");

  // A mode write lands in the register one edge later
  a_mode_write_lands: assert property ( // [R1]
    q.dph_wr && q.dph_addr == OFS_P0_MODE_HIGH |=> q.mode_high[0] == $past(ahb_req.hwdata[7:0]))
    else $error("mode high write not stored");

  // First cycle after reset shows reset register values
  a_reset_values_seen: assert property ( // [R12] [R13] [R16]
    !q.strap_done |-> q.in_dis == 8'h00 && q.mode_high == 16'hFFFF && q.mode_low == 16'h0000)
    else $error("registers not at reset values after reset");

  // Usable pin count follows the clock and reset options
  a_io_count_ok: assert property ( // [R14]
    q.strap_done |-> io_cnt == 4'h6 - {3'h0, q.ext_clk} - {3'h0, q.ext_rst})
    else $error("usable pin count wrong");

  // Shared reset pin never gets a driver
  a_reset_pin_idle: assert property ( // [R2]
    ((drv[1].pull_down | drv[1].strong_pu | drv[1].weak_pu | drv[1].vweak_pu) & P1_INPUT_ONLY)
      == 8'h00)
    else $error("shared reset pin driven");

  // Disabled port 0 inputs come back as zero
  a_dis_reads_zero: assert property ( // [R11]
    sel && !ahb_req.hwrite && ahb_req.haddr[7:0] == OFS_P0_PIN && !q.dph_wr
      |=> (ahb_rsp.hrdata[7:0] & $past(q.in_dis)) == 8'h00)
    else $error("disabled input read nonzero");

  // Enabled converter inputs read as zero too
  a_conv_reads_zero: assert property ( // [R15]
    sel && !ahb_req.hwrite && ahb_req.haddr[7:0] == OFS_P0_PIN && !q.dph_wr && q.conv_en
      |=> (ahb_rsp.hrdata[7:0] & $past(q.conv_sel)) == 8'h00)
    else $error("converter input read nonzero");

  for (genvar p = 0; p < 2; p++) begin : g_chk
    // Right after reset every pin is released
    a_reset_all_hiz: assert property ( // [R13]
      !q.strap_done |=> drv[p] == '0)
      else $error("pin driven after reset");

    for (genvar i = 0; i < PW; i++) begin : g_pin
      sequence s_quasi_rise;
        quasi[p][i] && $rose(q.latch[p][i]);
      endsequence
      sequence s_quasi_high;
        quasi[p][i] && q.latch[p][i];
      endsequence

      a_strong_two_cyc: assert property ( // [R5]
        s_quasi_rise ##1 s_quasi_high [*2]
          |-> drv[p].strong_pu[i] && $past(drv[p].strong_pu[i]) ##1 !drv[p].strong_pu[i])
        else $error("strong pull-up pulse not two cycles");

      a_quasi_vweak_on: assert property ( // [R3]
        s_quasi_high |=> drv[p].vweak_pu[i] && !drv[p].pull_down[i])
        else $error("very weak pull-up missing");

      a_quasi_weak_level: assert property ( // [R4]
        s_quasi_high |=> drv[p].weak_pu[i] == $past(level[p][i]))
        else $error("weak pull-up does not follow pin");

      a_quasi_low_sink: assert property ( // [R6]
        quasi[p][i] && !q.latch[p][i] |=> drv[p].pull_down[i] && !drv[p].vweak_pu[i]
          && !drv[p].strong_pu[i])
        else $error("quasi low not sinking");

      a_open_drain_pd: assert property ( // [R7]
        opend[p][i] |=> !drv[p].strong_pu[i] && !drv[p].weak_pu[i] && !drv[p].vweak_pu[i]
          && drv[p].pull_down[i] != $past(q.latch[p][i]))
        else $error("open drain drive wrong");

      a_push_pull_drv: assert property ( // [R9]
        pushp[p][i] |=> drv[p].strong_pu[i] == $past(q.latch[p][i])
          && drv[p].pull_down[i] != $past(q.latch[p][i]))
        else $error("push-pull drive wrong");

      a_input_only_off: assert property ( // [R10]
        inonly[p][i] |=> !drv[p].strong_pu[i] && !drv[p].weak_pu[i] && !drv[p].vweak_pu[i]
          && !drv[p].pull_down[i])
        else $error("input-only pin driven");
    end
  end
endmodule

// ==== pcfg_pkg.sv ====
// Purpose: shared constants and types for the configurable port pins
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: mode pair is written high bit first, then low bit
package pcfg_pkg;
  localparam int unsigned PW = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_P0_LATCH = 8'h00;
  localparam logic [7:0] OFS_P1_LATCH = 8'h04;
  localparam logic [7:0] OFS_P0_MODE_HIGH = 8'h08;
  localparam logic [7:0] OFS_P0_MODE_LOW = 8'h0C;
  localparam logic [7:0] OFS_P1_MODE_HIGH = 8'h10;
  localparam logic [7:0] OFS_P1_MODE_LOW = 8'h14;
  localparam logic [7:0] OFS_P0_IN_DIS = 8'h18;
  localparam logic [7:0] OFS_P0_PIN = 8'h1C;
  localparam logic [7:0] OFS_P1_PIN = 8'h20;
  localparam logic [7:0] OFS_CONV = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  // Field positions
  localparam int unsigned CONV_EN_BIT = 8;
  localparam int unsigned STAT_CLK_BIT = 4;
  localparam int unsigned STAT_RST_BIT = 5;
  // Values after reset
  localparam logic [PW-1:0] MODE_HIGH_RST = 8'hFF;
  localparam logic [PW-1:0] MODE_LOW_RST = 8'h00;
  localparam logic [PW-1:0] LATCH_RST = 8'hFF;
  localparam logic [PW-1:0] IN_DIS_RST = 8'h00;
  localparam logic [PW-1:0] CONV_SEL_RST = 8'h00;
  // Bonded pins and pins with a second use
  localparam logic [PW-1:0] P0_PRESENT = 8'h34;
  localparam logic [PW-1:0] P1_PRESENT = 8'h23;
  localparam logic [PW-1:0] P1_INPUT_ONLY = 8'h20;
  localparam logic [PW-1:0] P0_CLKIN_PIN = 8'h20;
  localparam logic [PW-1:0] P1_RESET_PIN = 8'h20;
  // Strong pull-up length in clock cycles
  localparam logic [1:0] STRONG_CYC = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    MODE_QUASI = 2'b00,
    MODE_PUSH_PULL = 2'b01,
    MODE_INPUT = 2'b10,
    MODE_OPEN_DRAIN = 2'b11
  } pcfg_mode_t;

  typedef struct packed {
    logic [PW-1:0] pull_down;
    logic [PW-1:0] strong_pu;
    logic [PW-1:0] weak_pu;
    logic [PW-1:0] vweak_pu;
  } pcfg_drive_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } pcfg_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } pcfg_ahb_rsp_t;

  // Mode of one pin from its two mode bits
  function automatic pcfg_mode_t pcfg_mode(input logic high, input logic low);
    return pcfg_mode_t'({high, low});
  endfunction

  function automatic logic [3:0] pcfg_popcnt(input logic [PW-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < PW; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction
endpackage

// ==== pcfg_pin_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for pad inputs
// Assumes: pads are asynchronous to hclk
// Notes: a level is taken only once stages two and three agree
`timescale 1ns/1ps
module pcfg_pin_sync #(parameter int unsigned W = 8) (
  input wire logic hclk, // Core clock
  input wire logic hresetn, // Async reset, active low
  input wire logic [W-1:0] pin_in, // Raw pad levels
  output logic [W-1:0] level // Filtered pad levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } pcfg_sync_st_t;
  pcfg_sync_st_t q, d;

  // Shift chain; the level moves only when two samples agree
  always_comb begin
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3)); // [R10]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule

// ==== pcfg_pin_drive.sv ====
// Purpose: pull-up and pull-down enables for one port of pins
// Assumes: mode bits already forced for fixed or taken pins
// Notes: all enables are registered, one cycle behind their inputs
`timescale 1ns/1ps
module pcfg_pin_drive (
  input wire logic hclk, // Core clock
  input wire logic hresetn, // Async reset, active low
  input wire logic [pcfg_pkg::PW-1:0] mode_high, // High mode bit per pin
  input wire logic [pcfg_pkg::PW-1:0] mode_low, // Low mode bit per pin
  input wire logic [pcfg_pkg::PW-1:0] latch, // Output latch per pin
  input wire logic [pcfg_pkg::PW-1:0] level, // Filtered pin level
  output pcfg_pkg::pcfg_drive_t drive // Registered driver enables
);
  import pcfg_pkg::*;
  typedef struct packed {
    logic [PW-1:0] prev;
    logic [PW-1:0][1:0] cnt;
    pcfg_drive_t drv;
  } pcfg_pd_st_t;
  pcfg_pd_st_t q, d;
  logic [PW-1:0] quasi, pushp, opend, rise, hold;

  // Mode decode and latch edge per pin
  always_comb begin
    for (int i = 0; i < PW; i++) begin
      quasi[i] = pcfg_mode(mode_high[i], mode_low[i]) == MODE_QUASI; // [R1]
      pushp[i] = pcfg_mode(mode_high[i], mode_low[i]) == MODE_PUSH_PULL; // [R1]
      opend[i] = pcfg_mode(mode_high[i], mode_low[i]) == MODE_OPEN_DRAIN; // [R1]
      hold[i] = q.cnt[i] != 2'h0;
    end
    rise = latch & ~q.prev;
  end

  // Next enables; input-only pins match no term and stay released
  always_comb begin
    d = q;
    d.prev = latch;
    for (int i = 0; i < PW; i++) begin
      if (quasi[i] && rise[i]) begin
        d.cnt[i] = STRONG_CYC - 2'h1; // [R5]
      end else if (hold[i]) begin
        d.cnt[i] = q.cnt[i] - 2'h1;
      end
    end
    d.drv.vweak_pu = quasi & latch; // [R3]
    d.drv.weak_pu = quasi & latch & level; // [R4]
    // Open drain never pulls up; the board supplies the high level [R7] [R8]
    d.drv.strong_pu = (pushp & latch) | (quasi & latch & (rise | hold)); // [R5] [R9]
    d.drv.pull_down = (quasi | opend | pushp) & ~latch; // [R6] [R7] [R9] [R10]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.prev <= LATCH_RST;
    end else begin
      q <= d;
    end
  end

  assign drive = q.drv;
endmodule

// ==== pcfg_pad_model.sv ====
// Purpose: pads and board circuits for one port of configurable pins
// Assumes: pull-down beats outside drivers, outside drivers beat pull-ups
// Notes: an undriven pad shows a pattern that changes every cycle
`timescale 1ns/1ps
module pcfg_pad_model (
  input wire logic hclk, // Core clock
  input wire pcfg_pkg::pcfg_drive_t drive, // Device driver enables
  input wire logic [pcfg_pkg::PW-1:0] ext_en, // Outside driver active
  input wire logic [pcfg_pkg::PW-1:0] ext_val, // Outside driver level
  input wire logic [pcfg_pkg::PW-1:0] ext_pu, // Board pull-up fitted
  output logic [pcfg_pkg::PW-1:0] level // Resolved pad level
);
  import pcfg_pkg::*;
  // Floating pads wander so no stale level can be read back
  logic [PW-1:0] float_q = 8'h55;
  always @(posedge hclk) begin
    float_q <= ~float_q;
  end
  // Resolve each pad from all parties
  always_comb begin
    for (int i = 0; i < PW; i++) begin
      if (drive.pull_down[i]) begin
        level[i] = 1'b0;
      end else if (ext_en[i]) begin
        level[i] = ext_val[i];
      end else if (ext_pu[i]) begin
        level[i] = 1'b1;
      end else if (drive.strong_pu[i] | drive.weak_pu[i] | drive.vweak_pu[i]) begin
        level[i] = 1'b1;
      end else begin
        level[i] = float_q[i];
      end
    end
  end
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench for the configurable port pins
// Assumes: zero wait-state slave, pads resolved by the pad model
// Notes: random rounds use an xorshift stream from a fixed seed
`timescale 1ns/1ps
module testbench;
  import pcfg_pkg::*;
  logic hclk, hresetn, hsel, hwrite, clk_sel, rst_sel;
  logic [31:0] haddr, hwdata, seed, rd;
  logic [1:0] htrans;
  logic [PW-1:0] en0, val0, pu0, en1, val1, lvl0, lvl1;
  pcfg_ahb_req_t req;
  pcfg_ahb_rsp_t rsp;
  pcfg_drive_t p0_drive, p1_drive;
  int mismatches, n_tests, cnt;
  // Bus request; hready follows the one slave
  assign req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2,
    hwdata: hwdata, hready: rsp.hreadyout};
  pcfg_port_top uut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp),
    .p0_pin_in(lvl0), .p1_pin_in(lvl1), .ext_clk_sel(clk_sel), .ext_reset_sel(rst_sel),
    .p0_drive(p0_drive), .p1_drive(p1_drive));
  pcfg_pad_model pad0 (.hclk(hclk), .drive(p0_drive), .ext_en(en0), .ext_val(val0),
    .ext_pu(pu0), .level(lvl0));
  pcfg_pad_model pad1 (.hclk(hclk), .drive(p1_drive), .ext_en(en1), .ext_val(val1),
    .ext_pu(8'h00), .level(lvl1));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Settled enables for mode, latch and outside drive; um marks usable pins
  function automatic pcfg_drive_t exp_drv(input logic [PW-1:0] mh, ml, lt, en, val, um);
    pcfg_drive_t e;
    e = '0;
    for (int i = 0; i < PW; i++) begin
      if (um[i] && ({mh[i], ml[i]} != MODE_INPUT)) begin
        e.pull_down[i] = !lt[i];
      end
      if (um[i] && ({mh[i], ml[i]} == MODE_PUSH_PULL)) begin
        e.strong_pu[i] = lt[i];
      end
      if (um[i] && ({mh[i], ml[i]} == MODE_QUASI)) begin
        e.vweak_pu[i] = lt[i];
        e.weak_pu[i] = lt[i] & (!en[i] | val[i]);
      end
    end
    return e;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Waits for hready high at a rising edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (rsp.hreadyout !== 1'b1 && n < 50);
    check("hready wait", 32'h1, 32'(n < 50));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= 32'(a);
    hwrite <= 1'b1;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] m);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= 32'(a);
    hwrite <= 1'b0;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    wait_rdy();
    rd = rsp.hrdata;
    check(what, exp & m, rd & m);
    check("response", 32'(HRESP_OKAY), 32'(rsp.hresp));
  endtask

  // One random configuration of both ports, then the settled enables
  task automatic rnd_round(input logic [PW-1:0] m0);
    logic [PW-1:0] v [8];
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      v[k] = seed[7:0];
    end
    en0 <= v[6];
    val0 <= v[7];
    en1 <= v[7];
    val1 <= v[6];
    wr(OFS_P0_MODE_HIGH, 32'(v[0]));
    wr(OFS_P0_MODE_LOW, 32'(v[1]));
    wr(OFS_P0_LATCH, 32'(v[2]));
    wr(OFS_P1_MODE_HIGH, 32'(v[3]));
    wr(OFS_P1_MODE_LOW, 32'(v[4]));
    wr(OFS_P1_LATCH, 32'(v[5]));
    repeat (10) @(posedge hclk);
    check("port0 drive", exp_drv(v[0], v[1], v[2], v[6], v[7], m0), p0_drive);
    check("port1 drive", exp_drv(v[3], v[4], v[5], v[7], v[6],
      P1_PRESENT & ~P1_INPUT_ONLY), p1_drive);
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    test_done();
  end

  initial begin
    {hresetn, hsel, hwrite, clk_sel, rst_sel, haddr, hwdata, htrans} = '0;
    {en0, val0, pu0, en1, val1} = '0;
    seed = 32'h46B0;
    mismatches = 0;
    n_tests = 0;
    repeat (4) @(posedge hclk);
    check("port0 in reset", 32'h0, p0_drive);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    check("port0 after reset", 32'h0, p0_drive);
    check("port1 after reset", 32'h0, p1_drive);
    rd_chk("p0 mode high", OFS_P0_MODE_HIGH, 32'(MODE_HIGH_RST), '1);
    rd_chk("p0 mode low", OFS_P0_MODE_LOW, 32'(MODE_LOW_RST), '1);
    rd_chk("p1 mode high", OFS_P1_MODE_HIGH, 32'(MODE_HIGH_RST), '1);
    rd_chk("p1 mode low", OFS_P1_MODE_LOW, 32'(MODE_LOW_RST), '1);
    rd_chk("input disable", OFS_P0_IN_DIS, 32'(IN_DIS_RST), '1);
    rd_chk("status", OFS_STATUS, 32'h06, 32'h3F);
    rd_chk("unmapped", 8'h3C, 32'h0, '1);
    // Port 1 pins read back through the filter while all are input only
    en1 <= 8'h23;
    val1 <= 8'h21;
    repeat (10) @(posedge hclk);
    rd_chk("port1 pins", OFS_P1_PIN, 32'h21, 32'(P1_PRESENT));
    repeat (20) rnd_round(P0_PRESENT);
    // Strong pull-up pulse on a quasi latch rise
    wr(OFS_P0_MODE_HIGH, 32'h00);
    wr(OFS_P0_MODE_LOW, 32'h00);
    wr(OFS_P0_LATCH, 32'h00);
    repeat (10) @(posedge hclk);
    wr(OFS_P0_LATCH, 32'h04);
    cnt = 0;
    repeat (12) begin
      @(negedge hclk);
      if (p0_drive.strong_pu[2] === 1'b1) cnt++;
    end
    @(posedge hclk);
    check("strong cycles", 32'(STRONG_CYC), 32'(cnt));
    // Pin reads through disable and converter selection
    wr(OFS_P0_MODE_HIGH, 32'hFF);
    en0 <= 8'h34;
    val0 <= 8'h14;
    repeat (10) @(posedge hclk);
    rd_chk("port0 pins", OFS_P0_PIN, 32'h14, 32'(P0_PRESENT));
    wr(OFS_P0_IN_DIS, 32'h04);
    rd_chk("disabled pin", OFS_P0_PIN, 32'h10, 32'(P0_PRESENT));
    wr(OFS_CONV, 32'h10);
    rd_chk("converter off", OFS_P0_PIN, 32'h10, 32'(P0_PRESENT));
    wr(OFS_CONV, 32'h110);
    rd_chk("converter on", OFS_P0_PIN, 32'h00, 32'(P0_PRESENT));
    wr(OFS_CONV, 32'h0);
    // Open drain with a board pull-up
    en0 <= 8'h00;
    pu0 <= 8'h10;
    wr(OFS_P0_MODE_HIGH, 32'h10);
    wr(OFS_P0_MODE_LOW, 32'h10);
    wr(OFS_P0_LATCH, 32'hFF);
    repeat (10) @(posedge hclk);
    rd_chk("open drain high", OFS_P0_PIN, 32'h10, 32'h10);
    wr(OFS_P0_LATCH, 32'hEF);
    repeat (10) @(posedge hclk);
    rd_chk("open drain low", OFS_P0_PIN, 32'h00, 32'h10);
    pu0 <= 8'h00;
    // Second reset with both pins taken
    wr(OFS_P0_IN_DIS, 32'hFF);
    hresetn <= 1'b0;
    clk_sel <= 1'b1;
    rst_sel <= 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("disable after reset", OFS_P0_IN_DIS, 32'h0, '1);
    rd_chk("status taken", OFS_STATUS, 32'h34, 32'h3F);
    repeat (10) rnd_round(P0_PRESENT & ~P0_CLKIN_PIN);
    test_done();
  end
endmodule
